/* shared/tcc_pkg.sv */
// Register map, field layout and constants of the conversion controller
package tcc_pkg;
  localparam int ADDR_W = 7;
  localparam int REG_BYTES = 12;
  localparam logic [6:0] ADDR_SETUP_A = 7'h00;
  localparam logic [6:0] ADDR_SETUP_B = 7'h01;
  localparam logic [6:0] ADDR_THRESH_BASE = 7'h05;
  localparam int THRESH_COUNT = 4;
  localparam logic [6:0] ADDR_RJ_OFFSET = 7'h09;
  localparam logic [6:0] ADDR_RJ_HIGH = 7'h0a;
  localparam logic [6:0] ADDR_RJ_LOW = 7'h0b;
  localparam int SPI_WRITE_BIT = 7;
  localparam int A_NOTCH50_BIT = 0;
  localparam int A_RJ_OFF_BIT = 3;
  localparam int A_ONESHOT_BIT = 6;
  localparam int A_AUTO_BIT = 7;
  localparam int B_AVG_LSB = 4;
  localparam int B_AVG_W = 3;
  localparam int B_TYPE_LSB = 0;
  localparam int B_TYPE_W = 4;
  localparam int TYPE_GAIN_BIT = 3;
  localparam int TYPE_GAIN32_BIT = 2;
  localparam logic [2:0] AVG_LOG2_MAX = 3'h4;
  localparam logic [7:0] SETUP_A_RESET = 8'h00;
  localparam logic [7:0] SETUP_B_RESET = 8'h00;
  localparam logic [7:0] THRESH_RESET = 8'h00;
  localparam logic [7:0] RJ_OFFSET_RESET = 8'h00;
  localparam logic [15:0] RJ_TEMP_RESET = 16'h0000;
  localparam logic [15:0] RJ_MAX = 16'h7ffc;
  localparam logic [15:0] RJ_MIN = 16'hc000;
  localparam logic [15:0] RJ_LSB_MASK = 16'hfffc;
  localparam int RJ_FRAC = 8;
  localparam int OFFSET_SHIFT = 4;
  localparam int RESULT_FRAC = 12;

  typedef enum logic [2:0] {
    TC_B, TC_E, TC_J, TC_K, TC_N, TC_R, TC_S, TC_T
  } tcc_tc_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_TC_START, ST_TC_WAIT, ST_RJ_START, ST_RJ_WAIT,
    ST_COMPENSATE, ST_LINEARIZE, ST_DONE
  } tcc_state_type;

  // Lookup table: converter codes per degree at gain 8 for each type
  function automatic logic [8:0] tcc_codes_per_degree(input logic [2:0] kind);
    logic [8:0] c;
    case (tcc_tc_type'(kind))
      TC_B: c = 9'h022;
      TC_E: c = 9'h100;
      TC_J: c = 9'h0c2;
      TC_K: c = 9'h08a;
      TC_N: c = 9'h07a;
      TC_R: c = 9'h023;
      TC_S: c = 9'h020;
      TC_T: c = 9'h0af;
      default: c = 9'h001;
    endcase
    return c;
  endfunction
endpackage

/* hw/tcc_spi_link.sv */
// Serial register port, clocked by the host's serial clock
`timescale 1ns/1ps
`default_nettype none
module tcc_spi_link #(
  parameter int REG_BYTES = tcc_pkg::REG_BYTES
) (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic rst,
  input wire logic sdi,
  input wire logic [8*REG_BYTES-1:0] regs_view,
  output logic sdo,
  output logic sdo_oe_n,
  output logic wr_toggle,
  output logic [6:0] wr_addr,
  output logic [7:0] wr_data,
  output logic rd_toggle
);
  logic [2:0] bit_cnt;
  logic [6:0] in_shift;
  logic first;
  logic wr_mode;
  logic [6:0] addr;
  logic [7:0] out_shift;

  wire [7:0] byte_in = {in_shift, sdi};
  wire byte_end = bit_cnt == 3'h7;
  wire addr_mapped = addr < 7'(REG_BYTES);
  wire [7:0] sel_byte = addr_mapped ? regs_view[{addr[3:0], 3'h0} +: 8]
                                    : 8'h00;
  wire load_out = bit_cnt == 3'h0 && !first && !wr_mode;
  wire rj_addr = addr == tcc_pkg::ADDR_RJ_HIGH ||
                 addr == tcc_pkg::ADDR_RJ_LOW;

  // Chip select high holds the whole frame logic in reset
  always_ff @(posedge sck or posedge cs_n) begin // RULE_15
    if (cs_n) begin
      bit_cnt <= 3'h0;
      in_shift <= 7'h00;
      first <= 1'b1;
      wr_mode <= 1'b0;
      addr <= 7'h00;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      in_shift <= byte_in[6:0];
      if (byte_end) begin
        first <= 1'b0;
        if (first) begin
          wr_mode <= byte_in[tcc_pkg::SPI_WRITE_BIT];
          addr <= byte_in[6:0];
        end else begin
          addr <= addr + 7'h01;
        end
      end
    end
  end

  // Toggles survive chip select so no false event reaches the core
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      wr_toggle <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
    end else if (byte_end && !first && wr_mode) begin
      wr_addr <= addr;
      wr_data <= byte_in;
      wr_toggle <= ~wr_toggle;
    end
  end

  always_ff @(negedge sck or posedge cs_n) begin // RULE_15
    if (cs_n) begin
      out_shift <= 8'h00;
      sdo_oe_n <= 1'b1;
    end else begin
      sdo_oe_n <= first || wr_mode;
      if (load_out) begin
        out_shift <= sel_byte;
      end else begin
        out_shift <= {out_shift[6:0], 1'b0};
      end
    end
  end

  always_ff @(negedge sck or posedge rst) begin
    if (rst) begin
      rd_toggle <= 1'b0;
    end else if (!cs_n && load_out && rj_addr) begin
      rd_toggle <= ~rd_toggle;
    end
  end

  assign sdo = out_shift[7];
endmodule // tcc_spi_link
`default_nettype wire

/* hw/tcc_core.sv */
// Thermocouple conversion sequencer with reference junction registers
//
// How it works
// [RULE_01] Setup A bit 0 picks 50 Hz or 60 Hz notch filtering.
// [RULE_02] Setup B bits 6:4 average 1, 2, 4, 8 or 16 samples, longer conversion.
// [RULE_03] Setup A bit 7 selects continuous conversions or normally off.
// [RULE_04] In normally-off mode, setting setup A bit 6 runs one conversion.
// [RULE_05] Setup B bits 3:0 select type K, J, N, R, S, T, B or E.
// [RULE_06] Other type codes give raw gain 8 or 32, no compensation.
// [RULE_07] Digitize, measure junction, table to code, add, table back.
// [RULE_08] Junction pair is read-only, measured plus offset, while sensor on.
// [RULE_09] Reading junction pair with sensor on drives data-ready high.
// [RULE_10] Host reads both junction bytes in one multibyte transfer.
// [RULE_11] Sensor off: pair keeps last value and accepts host writes.
// [RULE_12] Stored junction temperature saturates at 128 C and -64 C.
// [RULE_13] Offset register is added to the measured junction temperature.
// [RULE_14] Bias drives only while a conversion is running.
// [RULE_15] Serial port answers only while chip select is low.
// [RULE_16] Two setup bytes and four threshold bytes govern operation. The threshold bytes are only stored and read back; no logic uses them.
// [RULE_17] Offset is two's complement, 0.0625 C step, resets to zero.
// [RULE_18] Setup A bit 3 turns the internal junction sensor off.
// [RULE_19] Junction word has 1/64 C steps, two low bits always zero.
// [RULE_20] Finished one-shot clears its request bit and asserts data-ready.
// [RULE_21] Setup changes take effect from the next conversion onward; setup A bit 3 acts at once, in the running conversion.
`timescale 1ns/1ps
`default_nettype none
module tcc_core #(
  parameter int FE_W = 19,
  parameter int RESULT_W = 24
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  output logic result_waiting_out_n,
  output logic bias_drive_n,
  output logic fe_start,
  output logic fe_channel,
  output logic fe_notch_50,
  output logic fe_gain_32,
  input wire logic fe_done,
  input wire logic signed [FE_W-1:0] fe_data,
  output logic signed [RESULT_W-1:0] result_temp
);
  localparam int VIEW_W = 8 * tcc_pkg::REG_BYTES;
  localparam int ACC_W = FE_W + 5;
  localparam int DIV_W = ACC_W + tcc_pkg::RESULT_FRAC;

  function automatic logic [15:0] rj_saturate(input logic signed [17:0] v);
    logic signed [17:0] hi;
    logic signed [17:0] lo;
    logic [15:0] r;
    hi = $signed({{2{tcc_pkg::RJ_MAX[15]}}, tcc_pkg::RJ_MAX});
    lo = $signed({{2{tcc_pkg::RJ_MIN[15]}}, tcc_pkg::RJ_MIN});
    if (v > hi) begin
      r = tcc_pkg::RJ_MAX;
    end else if (v < lo) begin
      r = tcc_pkg::RJ_MIN;
    end else begin
      r = v[15:0];
    end
    return r & tcc_pkg::RJ_LSB_MASK;
  endfunction

  logic [7:0] setup_a;
  logic [7:0] setup_b;
  logic [tcc_pkg::THRESH_COUNT-1:0][7:0] thresh;
  logic [7:0] ref_offset;
  logic [15:0] ref_temp;
  logic [VIEW_W-1:0] regs_view;
  logic wr_toggle;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_toggle;
  logic [2:0] wr_sync;
  logic [2:0] rd_sync;
  logic [1:0] cs_sync;
  tcc_pkg::tcc_state_type state;
  tcc_pkg::tcc_state_type next_state;
  logic [2:0] cur_avg;
  logic [3:0] cur_type;
  logic [4:0] sample_cnt;
  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] tc_code;
  logic signed [ACC_W-1:0] comp_sum;

  tcc_spi_link #(
    .REG_BYTES(tcc_pkg::REG_BYTES)
  ) u_link (
    .sck(sck),
    .cs_n(cs_n),
    .rst(rst),
    .sdi(sdi),
    .regs_view(regs_view),
    .sdo(sdo),
    .sdo_oe_n(sdo_oe_n),
    .wr_toggle(wr_toggle),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_toggle(rd_toggle)
  );

  // Address and data stay still for a whole byte time after a toggle
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_sync <= 3'h0;
      rd_sync <= 3'h0;
      cs_sync <= 2'h3;
    end else begin
      wr_sync <= {wr_sync[1:0], wr_toggle};
      rd_sync <= {rd_sync[1:0], rd_toggle};
      cs_sync <= {cs_sync[0], cs_n};
    end
  end

  wire wr_pulse = wr_sync[2] ^ wr_sync[1];
  wire rd_pulse = rd_sync[2] ^ rd_sync[1];
  wire cs_idle = cs_sync[1];
  wire rj_enabled = !setup_a[tcc_pkg::A_RJ_OFF_BIT]; // RULE_18
  wire wr_a = wr_pulse && wr_addr == tcc_pkg::ADDR_SETUP_A;
  wire wr_b = wr_pulse && wr_addr == tcc_pkg::ADDR_SETUP_B;
  wire wr_ofs = wr_pulse && wr_addr == tcc_pkg::ADDR_RJ_OFFSET;
  wire wr_rjh = wr_pulse && wr_addr == tcc_pkg::ADDR_RJ_HIGH;
  wire wr_rjl = wr_pulse && wr_addr == tcc_pkg::ADDR_RJ_LOW;
  wire host_rj_write = (wr_rjh || wr_rjl) && !rj_enabled; // RULE_11
  wire [15:0] host_rj = wr_rjh ? {wr_data, ref_temp[7:0]}
                               : {ref_temp[15:8], wr_data};
  wire signed [17:0] meas_sum =
    $signed({{2{fe_data[15]}}, fe_data[15:0]}) +
    $signed({{(10 - tcc_pkg::OFFSET_SHIFT){ref_offset[7]}}, ref_offset,
             {tcc_pkg::OFFSET_SHIFT{1'b0}}}); // RULE_13 RULE_17
  wire conv_done = state == tcc_pkg::ST_DONE;
  wire go = setup_a[tcc_pkg::A_AUTO_BIT] ||
            setup_a[tcc_pkg::A_ONESHOT_BIT]; // RULE_03 RULE_04
  wire [2:0] avg_field = setup_b[tcc_pkg::B_AVG_LSB +: tcc_pkg::B_AVG_W];
  wire [2:0] avg_log2 = avg_field > tcc_pkg::AVG_LOG2_MAX ?
                        tcc_pkg::AVG_LOG2_MAX : avg_field; // RULE_02
  wire [3:0] type_field = setup_b[tcc_pkg::B_TYPE_LSB +: tcc_pkg::B_TYPE_W];
  wire gain_mode = cur_type[tcc_pkg::TYPE_GAIN_BIT]; // RULE_06
  wire [4:0] sample_last = 5'((5'h01 << cur_avg) - 5'h01);
  wire signed [ACC_W-1:0] acc_next = acc + ACC_W'(fe_data);
  wire [8:0] coeff = tcc_pkg::tcc_codes_per_degree(cur_type[2:0]);
  wire signed [25:0] rj_product = $signed(ref_temp) * $signed({1'b0, coeff});
  wire signed [ACC_W-1:0] rj_code =
    ACC_W'(rj_product >>> tcc_pkg::RJ_FRAC);
  wire signed [DIV_W-1:0] lin_num =
    $signed({comp_sum, {tcc_pkg::RESULT_FRAC{1'b0}}});
  wire signed [DIV_W-1:0] lin_div = $signed({{(DIV_W - 9){1'b0}}, coeff});
  wire signed [DIV_W-1:0] lin_quot = lin_num / lin_div;
  // Averaging needs a fresh front-end start for every sample
  wire more_samples = state == tcc_pkg::ST_TC_WAIT && fe_done &&
                      sample_cnt != sample_last;

  // Setup bytes and offset; a host write beats the self-clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      setup_a <= tcc_pkg::SETUP_A_RESET;
      setup_b <= tcc_pkg::SETUP_B_RESET;
      ref_offset <= tcc_pkg::RJ_OFFSET_RESET; // RULE_17
    end else begin
      if (wr_a) begin
        setup_a <= wr_data; // RULE_16
      end else if (conv_done) begin
        setup_a[tcc_pkg::A_ONESHOT_BIT] <= 1'b0; // RULE_20
      end
      if (wr_b) begin
        setup_b <= wr_data; // RULE_16
      end
      if (wr_ofs) begin
        ref_offset <= wr_data;
      end
    end
  end

  generate
    for (genvar i = 0; i < tcc_pkg::THRESH_COUNT; i++) begin : g_thresh
      wire hit = wr_pulse && wr_addr == tcc_pkg::ADDR_THRESH_BASE + 7'(i);
      always_ff @(posedge mclk) begin
        if (rst) begin
          thresh[i] <= tcc_pkg::THRESH_RESET;
        end else if (hit) begin
          thresh[i] <= wr_data; // RULE_16
        end
      end
    end
  endgenerate

  // Measured value lands only while the sensor is on; writes only when off
  always_ff @(posedge mclk) begin
    if (rst) begin
      ref_temp <= tcc_pkg::RJ_TEMP_RESET;
    end else if (state == tcc_pkg::ST_RJ_WAIT && fe_done) begin
      ref_temp <= rj_saturate(meas_sum); // RULE_08 RULE_12 RULE_19
    end else if (host_rj_write) begin
      ref_temp <= rj_saturate($signed({{2{host_rj[15]}}, host_rj}));
    end
  end

  // Frozen during a frame so a multibyte read sees one update
  always_ff @(posedge mclk) begin
    if (rst) begin
      regs_view <= '0;
    end else if (cs_idle) begin
      regs_view <= {ref_temp[7:0], ref_temp[15:8], ref_offset, thresh,
                    24'h000000, setup_b, setup_a}; // RULE_10
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      result_waiting_out_n <= 1'b1;
    end else if (conv_done) begin
      result_waiting_out_n <= 1'b0; // RULE_20
    end else if (rd_pulse && rj_enabled) begin
      result_waiting_out_n <= 1'b1; // RULE_09
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      tcc_pkg::ST_IDLE:
        if (go) begin
          next_state = tcc_pkg::ST_TC_START;
        end
      tcc_pkg::ST_TC_START: next_state = tcc_pkg::ST_TC_WAIT;
      tcc_pkg::ST_TC_WAIT:
        if (fe_done && sample_cnt == sample_last) begin
          next_state = rj_enabled ? tcc_pkg::ST_RJ_START
                     : gain_mode ? tcc_pkg::ST_DONE
                     : tcc_pkg::ST_COMPENSATE; // RULE_07
        end
      tcc_pkg::ST_RJ_START: next_state = tcc_pkg::ST_RJ_WAIT;
      tcc_pkg::ST_RJ_WAIT:
        if (fe_done) begin
          next_state = gain_mode ? tcc_pkg::ST_DONE
                                 : tcc_pkg::ST_COMPENSATE; // RULE_06
        end
      tcc_pkg::ST_COMPENSATE: next_state = tcc_pkg::ST_LINEARIZE;
      tcc_pkg::ST_LINEARIZE: next_state = tcc_pkg::ST_DONE;
      tcc_pkg::ST_DONE: next_state = tcc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= tcc_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Settings are taken once per conversion, at its start
  always_ff @(posedge mclk) begin
    if (rst) begin
      cur_avg <= 3'h0;
      cur_type <= 4'h0;
      fe_notch_50 <= 1'b0;
      fe_gain_32 <= 1'b0;
    end else if (state == tcc_pkg::ST_IDLE && go) begin
      cur_avg <= avg_log2; // RULE_21 RULE_02
      cur_type <= type_field; // RULE_05 RULE_21
      fe_notch_50 <= setup_a[tcc_pkg::A_NOTCH50_BIT]; // RULE_01 RULE_21
      fe_gain_32 <= type_field[tcc_pkg::TYPE_GAIN_BIT] &&
                    type_field[tcc_pkg::TYPE_GAIN32_BIT]; // RULE_06
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fe_start <= 1'b0;
      fe_channel <= 1'b0;
      bias_drive_n <= 1'b1;
    end else begin
      fe_start <= next_state == tcc_pkg::ST_TC_START ||
                  next_state == tcc_pkg::ST_RJ_START ||
                  more_samples; // RULE_02
      fe_channel <= next_state == tcc_pkg::ST_RJ_START ||
                    next_state == tcc_pkg::ST_RJ_WAIT;
      bias_drive_n <= next_state == tcc_pkg::ST_IDLE; // RULE_14
    end
  end

  // Each averaged sample restarts the front end
  always_ff @(posedge mclk) begin
    if (rst) begin
      sample_cnt <= 5'h00;
      acc <= '0;
      tc_code <= '0;
    end else if (state == tcc_pkg::ST_TC_START) begin
      sample_cnt <= 5'h00;
      acc <= '0;
    end else if (state == tcc_pkg::ST_TC_WAIT && fe_done) begin
      sample_cnt <= sample_cnt + 5'h01;
      acc <= acc_next;
      tc_code <= acc_next >>> cur_avg; // RULE_02
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      comp_sum <= '0;
      result_temp <= '0;
    end else if (state == tcc_pkg::ST_COMPENSATE) begin
      comp_sum <= tc_code + rj_code; // RULE_07
    end else if (state == tcc_pkg::ST_LINEARIZE) begin
      result_temp <= lin_quot[RESULT_W-1:0]; // RULE_07 RULE_05
    end else if (state == tcc_pkg::ST_DONE && gain_mode) begin
      result_temp <= RESULT_W'(tc_code); // RULE_06
    end
  end
endmodule // tcc_core
`default_nettype wire

/* verification/tcc_core_checker.sv */
// Concurrent checks on the conversion controller ports
`timescale 1ns/1ps
`default_nettype none
module tcc_core_checker #(
  parameter int FE_W = 19,
  parameter int RESULT_W = 24
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  input wire logic result_waiting_out_n,
  input wire logic bias_drive_n,
  input wire logic fe_start,
  input wire logic fe_channel,
  input wire logic fe_notch_50,
  input wire logic fe_gain_32,
  input wire logic fe_done,
  input wire logic signed [FE_W-1:0] fe_data,
  input wire logic signed [RESULT_W-1:0] result_temp
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence seq_quiet;
    bias_drive_n && result_waiting_out_n && !fe_start;
  endsequence
  sequence seq_junction_done;
    fe_done && fe_channel && !bias_drive_n;
  endsequence
  sequence seq_finish;
    ##[2:6] $rose(bias_drive_n);
  endsequence

  AST_RESET_QUIET: assert property ($fell(rst) |-> seq_quiet [*4])
    else $error("conversion activity right after reset");
  AST_START_PULSE: assert property (fe_start |=> !fe_start)
    else $error("front end start longer than one cycle");
  AST_START_BIAS: assert property (fe_start |-> !bias_drive_n)
    else $error("sample started without bias");
  AST_JUNCTION_START: assert property ($rose(fe_channel) |-> fe_start)
    else $error("junction channel selected without a start");
  AST_FINISH: assert property (seq_junction_done |-> seq_finish)
    else $error("conversion did not end after junction sample");
  AST_READY_BIAS: assert property (
    $fell(result_waiting_out_n) |-> $rose(bias_drive_n))
    else $error("data ready without end of conversion");
  AST_SETUP_HELD: assert property (
    !bias_drive_n && !$past(bias_drive_n)
      |-> $stable(fe_gain_32) && $stable(fe_notch_50))
    else $error("gain or notch changed inside a conversion");
  AST_RESULT_HELD: assert property (
    bias_drive_n && $past(bias_drive_n) |-> $stable(result_temp))
    else $error("result changed while idle");
  AST_OE_SELECT: assert property (cs_n |-> sdo_oe_n)
    else $error("serial output driven while deselected");
endmodule // tcc_core_checker

bind tcc_core tcc_core_checker #(.FE_W(FE_W), .RESULT_W(RESULT_W)) i_chk (
  .mclk(mclk), .rst(rst), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo),
  .sdo_oe_n(sdo_oe_n), .result_waiting_out_n(result_waiting_out_n),
  .bias_drive_n(bias_drive_n), .fe_start(fe_start),
  .fe_channel(fe_channel), .fe_notch_50(fe_notch_50),
  .fe_gain_32(fe_gain_32), .fe_done(fe_done), .fe_data(fe_data),
  .result_temp(result_temp));
`default_nettype wire

/* verification/tcc_host_model.sv */
// Host serial controller model for the register port
`timescale 1ns/1ps
`default_nettype none
module tcc_host_model (
  output logic cs_n,
  output logic sck,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end

  // Header then two bytes, so both junction bytes share one update
  task automatic frame(input logic [7:0] hdr, input logic [15:0] wd,
    output logic [15:0] rd);
    logic [23:0] sh;
    sh = {hdr, wd};
    rd = 16'h0000;
    cs_n = 1'b0;
    #100;
    for (int i = 23; i >= 0; i--) begin
      sdi = sh[i];
      #62.5 sck = 1'b1;
      if (i < 16) rd = {rd[14:0], sdo_oe_n ? 1'bx : sdo};
      #62.5 sck = 1'b0;
    end
    #100 cs_n = 1'b1;
    // Released line must not keep looking like data
    sdi = ~sdi;
    #400;
  endtask
endmodule // tcc_host_model
`default_nettype wire

/* verification/tcc_core_test.sv */
// Self-checking bench for the conversion controller
`timescale 1ns/1ps
`default_nettype none
module tcc_core_test;
  typedef struct {
    logic [23:0] res;
    int starts;
    logic g32;
    logic n50;
  } tcc_note_type;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sck, sdi, sdo, sdo_oe_n, result_waiting_out_n, bias_drive_n;
  logic fe_start, fe_channel, fe_notch_50, fe_gain_32, g32, n50;
  logic fe_done = 1'b0;
  logic signed [18:0] fe_data = 19'sh00000;
  logic signed [23:0] result_temp;
  logic [18:0] tc_in = 19'h00000;
  logic [15:0] rj_in = 16'h0000;
  logic [2:0] fe_left = 3'h0;
  tcc_note_type notes[$];
  tcc_note_type auto_note;
  tcc_note_type nt;
  bit auto_run = 1'b0;
  bit loose = 1'b0;
  bit bias_prev = 1'b1;
  int nstarts = 0;
  int conv_count = 0;
  int bad_count = 0;
  int samples_checked = 0;

  always #50 mclk = ~mclk;

  tcc_core #(.FE_W(19), .RESULT_W(24)) i_dut (
    .mclk(mclk), .rst(rst), .cs_n(cs_n), .sck(sck), .sdi(sdi),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .result_waiting_out_n(result_waiting_out_n),
    .bias_drive_n(bias_drive_n), .fe_start(fe_start),
    .fe_channel(fe_channel), .fe_notch_50(fe_notch_50),
    .fe_gain_32(fe_gain_32), .fe_done(fe_done), .fe_data(fe_data),
    .result_temp(result_temp));

  tcc_host_model i_host (.cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n));

  task automatic check(input string what, input logic [23:0] seen,
    input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] rj_exp(input logic [15:0] d,
    input logic [7:0] o);
    int s;
    s = int'($signed(d)) + 16 * int'($signed(o));
    if (s > 32764) s = 32764;
    if (s < -16384) s = -16384;
    return 16'(s) & 16'hfffc;
  endfunction

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] r;
    i_host.frame({1'b1, a}, d, r);
  endtask

  task automatic rd_chk(input string w, input logic [6:0] a,
    input logic [15:0] e);
    logic [15:0] r;
    i_host.frame({1'b0, a}, 16'h0000, r);
    check(w, 24'(r), 24'(e));
  endtask

  task automatic shot(input logic [7:0] a, input logic [7:0] b,
    input tcc_note_type n);
    wr(7'h01, {b, 8'h00});
    notes.push_back(n);
    wr(7'h00, {a | 8'h40, b});
    for (int i = 0; i < 3000 && notes.size() != 0; i++) @(negedge mclk);
    check("pending", 24'(notes.size()), 24'h0);
  endtask

  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Front end answers each start after a random delay
  always @(negedge mclk) begin
    if (fe_start) fe_left <= 3'h1 + 3'($urandom % 4);
    else if (fe_left != 3'h0) fe_left <= fe_left - 3'h1;
    fe_done <= !fe_start && fe_left == 3'h1;
    fe_data <= (fe_channel ? 19'($signed(rj_in)) : tc_in)
      ^ {19{fe_left != 3'h1}};
  end

  always @(negedge mclk) begin
    if (fe_start) begin
      nstarts++;
      g32 = fe_gain_32;
      n50 = fe_notch_50;
    end
    if (bias_drive_n && !bias_prev) begin
      if (!auto_run && notes.size() == 0) begin
        check("extra conversion", 24'h1, 24'h0);
      end else begin
        if (auto_run) nt = auto_note;
        else nt = notes.pop_front();
        check("result", result_temp, nt.res);
        check("samples", 24'(nstarts), 24'(nt.starts));
        if (!loose) check("gain", 24'(g32), 24'(nt.g32));
        check("notch", 24'(n50), 24'(nt.n50));
      end
      nstarts = 0;
      conv_count++;
    end
    bias_prev = bias_drive_n;
  end

  initial begin
    #3000000;
    bad_count++;
    final_report();
  end

  initial begin
    logic [7:0] off;
    logic [7:0] b;
    logic nb;
    logic [2:0] av;
    int c0;
    void'($urandom(32'h811bf843));
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    rd_chk("setup", 7'h00, 16'h0000);
    rd_chk("offset", 7'h08, 16'h0000);
    for (int t = 0; t < 16; t++) begin
      av = 3'($urandom % 8);
      nb = 1'($urandom % 2);
      b = {1'b0, av, 4'(t)};
      tc_in = (t < 8) ? 19'h00000 : 19'($urandom);
      rj_in = (t < 8) ? 16'h1900 : (t == 15) ? 16'h7ff0 :
        (t == 14) ? 16'h1903 : 16'($urandom);
      off = (t < 8) ? 8'h00 : (t == 15) ? 8'h7f :
        (t == 14) ? 8'h10 : 8'($urandom);
      wr(7'h08, {8'h00, off});
      // Zero input with junction at 25 C must read 25 C
      shot({7'h00, nb}, b, '{(t < 8) ? 24'h019000 :
        {{5{tc_in[18]}}, tc_in},
        (1 << ((av > 4) ? 4 : av)) + 1, t >= 12, nb});
      check("ready low", 24'(result_waiting_out_n), 24'h0);
      rd_chk("setup back", 7'h00, {7'h00, nb, b});
      rd_chk("junction", 7'h0a, rj_exp(rj_in, off));
      check("ready high", 24'(result_waiting_out_n), 24'h1);
    end
    shot(8'h08, 8'h08, '{{{5{tc_in[18]}}, tc_in}, 1, 1'b0, 1'b0});
    rd_chk("kept", 7'h0a, 16'h7ffc);
    check("ready kept", 24'(result_waiting_out_n), 24'h0);
    wr(7'h0a, 16'h1237);
    rd_chk("external", 7'h0a, 16'h1234);
    wr(7'h00, 16'h0008);
    wr(7'h0a, 16'h5555);
    rd_chk("read only", 7'h0a, 16'h1234);
    wr(7'h05, 16'h3cc3);
    rd_chk("thresholds", 7'h05, 16'h3cc3);
    wr(7'h02, 16'ha5a5);
    rd_chk("unmapped", 7'h02, 16'h0000);
    auto_note = '{{{5{tc_in[18]}}, tc_in}, 2, 1'b0, 1'b0};
    auto_run = 1'b1;
    wr(7'h00, 16'h8008);
    repeat (300) @(negedge mclk);
    loose = 1'b1;
    wr(7'h01, 16'h0c00);
    c0 = conv_count;
    for (int i = 0; i < 500 && conv_count < c0 + 2; i++) @(negedge mclk);
    auto_note.g32 = 1'b1;
    loose = 1'b0;
    repeat (300) @(negedge mclk);
    wr(7'h00, 16'h000c);
    repeat (100) @(negedge mclk);
    c0 = conv_count;
    repeat (500) @(negedge mclk);
    check("stopped", 24'(conv_count - c0), 24'h0);
    check("ran", 24'(c0 > 5), 24'h1);
    final_report();
  end
endmodule // tcc_core_test
`default_nettype wire
